// >>> src/amlc_cfg.svh
`ifndef AMLC_CFG_SVH
`define AMLC_CFG_SVH

// ------------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------------
`define AMLC_OFS_CTRL     8'h00
`define AMLC_OFS_STATUS   8'h04
`define AMLC_OFS_CFG      8'h08
`define AMLC_OFS_IRQ_STS  8'h0c
`define AMLC_OFS_IRQ_MSK  8'h10

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define AMLC_CTRL_WMASK   16'h07fc
`define AMLC_CTRL_RST     16'h0000
`define AMLC_LATCH_DIS    2
`define AMLC_CFG_PIN_EN   2
`define AMLC_CFG_RST      3'h0
`define AMLC_IRQ_NEWFLAG  0
`define AMLC_IRQ_PINLOW   1
`define AMLC_RESP_OKAY    2'h0
`define AMLC_RESP_SLVERR  2'h2

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define AMLC_CLK_MHZ      200
`define AMLC_CONV_NS      2000
`define AMLC_CONV_CYC     ((`AMLC_CONV_NS * `AMLC_CLK_MHZ) / 1000)

`endif

// >>> src/amlc_pkg.sv
package amlc_pkg;

   typedef logic [8:0] amlc_src_t;

   typedef struct packed {
      amlc_src_t   sync1;
      amlc_src_t   sync2;
      amlc_src_t   flags;
      logic [15:0] ctrl;
      logic [2:0]  cfg;
      logic [1:0]  irq_sts;
      logic [1:0]  irq_msk;
      logic [8:0]  div;
      logic        sample;
      logic        pin_n;
      logic        irq;
      logic        awready;
      logic        wready;
      logic        aw_hold;
      logic        w_hold;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } amlc_top_st_t;

   typedef struct packed {
      logic [35:0] cnt;
      amlc_src_t   qual;
      logic        done;
   } amlc_filt_st_t;

endpackage : amlc_pkg

// >>> src/amlc_filt_if.sv
`timescale 1ns/1ps
interface amlc_filt_if;
   logic             sample;
   logic [1:0]       count_sel;
   amlc_pkg::amlc_src_t raw;
   amlc_pkg::amlc_src_t qual;
   logic             done;
   modport filt (input sample, count_sel, raw, output qual, done);
   modport ctrl (output sample, count_sel, raw, input qual, done);
endinterface : amlc_filt_if

// >>> src/amlc_filt.sv
`timescale 1ns/1ps
module amlc_filt (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_n_i,
   // Link to control logic
   amlc_filt_if.filt fi
);
   amlc_pkg::amlc_filt_st_t st_r;
   amlc_pkg::amlc_filt_st_t st_nxt;

   function automatic logic [3:0] need_cnt(input logic [1:0] sel);
      need_cnt = 4'h1 << sel;
   endfunction : need_cnt

   always_comb begin
      logic [3:0] c;
      c = 4'h0;
      st_nxt = st_r;
      st_nxt.done = fi.sample;
      for (int i = 0; i < 9; i++) begin
         c = st_r.cnt[i*4 +: 4];
         if (fi.sample) begin
            // A return to range restarts the run of samples.
            if (!fi.raw[i]) begin
               c = 4'h0;
            end else if (c < need_cnt(fi.count_sel)) begin
               c = c + 4'h1;
            end
            st_nxt.qual[i] = (c >= need_cnt(fi.count_sel));
         end
         st_nxt.cnt[i*4 +: 4] = c;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fi.qual = st_r.qual;
   assign fi.done = st_r.done;

   qual_on_sample_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(st_r.qual[0]) |-> $past(fi.sample) && $past(fi.raw[0]))
      else $error("qualified alarm rose without an out-of-range sample");

endmodule : amlc_filt

// >>> src/amlc_top.sv
`timescale 1ns/1ps
`include "amlc_cfg.svh"
module amlc_top (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   // Alarm conditions from the monitors, asynchronous
   input  wire logic [8:0]  alarm_cond_i,
   // Alarm pin and interrupt
   output logic             event_pin_n_o,
   output logic             irq_o,
   // AXI4-Lite write address and data
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   // AXI4-Lite write response
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   output logic [1:0]       s_axi_bresp_o,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   input  wire logic [7:0]  s_axi_araddr_i,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   amlc_pkg::amlc_top_st_t st_r;
   amlc_pkg::amlc_top_st_t st_nxt;
   amlc_filt_if            fi ();

   amlc_filt u_filt (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .fi        (fi)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Sources sit at status bits 10:3, the thermal flag at bit 0.
   function automatic logic [15:0] to_status(input logic [8:0] v);
      to_status = {5'h00, v[8:1], 2'h0, v[0]};
   endfunction : to_status

   function automatic logic [31:0] merge_w(input logic [31:0] old,
                                           input logic [31:0] val,
                                           input logic [3:0]  strb);
      for (int b = 0; b < 4; b++) begin
         merge_w[b*8 +: 8] = strb[b] ? val[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction : merge_w

   // The thermal source has no unmask bit and is always live.
   function automatic logic [8:0] live_mask(input logic [15:0] c);
      live_mask = {c[10:3], 1'b1};
   endfunction : live_mask

   assign fi.sample    = st_r.sample;
   assign fi.count_sel = st_r.cfg[1:0];
   assign fi.raw       = st_r.sync2;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic        rd_status;
      logic [8:0]  set_v;
      logic [1:0]  irq_clr;
      logic [1:0]  irq_ev;
      logic [31:0] wv;
      rd_status = 1'b0;
      set_v     = 9'h000;
      irq_clr   = 2'h0;
      irq_ev    = 2'h0;
      wv        = 32'h0000_0000;
      st_nxt    = st_r;

      // Pins are asynchronous, so two stages before any use.
      st_nxt.sync1 = alarm_cond_i;
      st_nxt.sync2 = st_r.sync1;

      // Conversion tick.
      if (st_r.div == 9'((`AMLC_CONV_CYC) - 1)) begin
         st_nxt.div    = 9'h000;
         st_nxt.sample = 1'b1;
      end else begin
         st_nxt.div    = st_r.div + 9'h001;
         st_nxt.sample = 1'b0;
      end

      // Write channel.
      if (st_r.bvalid && s_axi_bready_i) begin
         st_nxt.bvalid = 1'b0;
      end
      if (s_axi_awvalid_i && st_r.awready) begin
         st_nxt.aw_hold = 1'b1;
         st_nxt.awaddr  = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && st_r.wready) begin
         st_nxt.w_hold = 1'b1;
         st_nxt.wdata  = s_axi_wdata_i;
         st_nxt.wstrb  = s_axi_wstrb_i;
      end
      if (st_nxt.aw_hold && st_nxt.w_hold && !st_nxt.bvalid) begin
         st_nxt.aw_hold = 1'b0;
         st_nxt.w_hold  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = `AMLC_RESP_OKAY;
         case (st_nxt.awaddr)
            `AMLC_OFS_CTRL: begin
               wv = merge_w({16'h0000, st_r.ctrl}, st_nxt.wdata,
                            st_nxt.wstrb);
               // Reserved bits never take a write.
               st_nxt.ctrl = wv[15:0] & `AMLC_CTRL_WMASK;
            end
            `AMLC_OFS_CFG: begin
               wv = merge_w({29'h0, st_r.cfg}, st_nxt.wdata,
                            st_nxt.wstrb);
               st_nxt.cfg = wv[2:0];
            end
            `AMLC_OFS_IRQ_STS: begin
               irq_clr = st_nxt.wstrb[0] ? st_nxt.wdata[1:0] : 2'h0;
            end
            `AMLC_OFS_IRQ_MSK: begin
               wv = merge_w({30'h0, st_r.irq_msk}, st_nxt.wdata,
                            st_nxt.wstrb);
               st_nxt.irq_msk = wv[1:0];
            end
            `AMLC_OFS_STATUS: begin
               st_nxt.bresp = `AMLC_RESP_OKAY;
            end
            default: begin
               st_nxt.bresp = `AMLC_RESP_SLVERR;
            end
         endcase
      end
      st_nxt.awready = !st_nxt.aw_hold && !st_nxt.bvalid;
      st_nxt.wready  = !st_nxt.w_hold && !st_nxt.bvalid;

      // Read channel.
      if (st_r.rvalid && s_axi_rready_i) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = `AMLC_RESP_OKAY;
         case (s_axi_araddr_i)
            `AMLC_OFS_CTRL: begin
               st_nxt.rdata = {16'h0000, st_r.ctrl};
            end
            `AMLC_OFS_STATUS: begin
               st_nxt.rdata = {16'h0000, to_status(st_r.flags)};
               rd_status    = 1'b1;
            end
            `AMLC_OFS_CFG: begin
               st_nxt.rdata = {29'h0, st_r.cfg};
            end
            `AMLC_OFS_IRQ_STS: begin
               st_nxt.rdata = {30'h0, st_r.irq_sts};
            end
            `AMLC_OFS_IRQ_MSK: begin
               st_nxt.rdata = {30'h0, st_r.irq_msk};
            end
            default: begin
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.rresp = `AMLC_RESP_SLVERR;
            end
         endcase
      end
      st_nxt.arready = !st_nxt.rvalid;

      // Alarm flags. A flag is set only by a finished, qualified
      // conversion; a read in that same cycle loses to the set.
      set_v = fi.done ? fi.qual : 9'h000;
      if (st_r.ctrl[`AMLC_LATCH_DIS]) begin
         st_nxt.flags = fi.qual;
      end else if (rd_status) begin
         st_nxt.flags = set_v;
      end else begin
         st_nxt.flags = st_r.flags | set_v;
      end

      // Masked flags stay visible in status but leave the pin alone.
      st_nxt.pin_n = !(st_r.cfg[`AMLC_CFG_PIN_EN] &&
                       |(st_r.flags & live_mask(st_r.ctrl)));

      // Interrupt events; a new event beats a same-cycle clear.
      irq_ev[`AMLC_IRQ_NEWFLAG] = |(st_nxt.flags & ~st_r.flags);
      irq_ev[`AMLC_IRQ_PINLOW]  = st_r.pin_n && !st_nxt.pin_n;
      st_nxt.irq_sts = (st_r.irq_sts & ~irq_clr) | irq_ev;
      st_nxt.irq     = |(st_nxt.irq_sts & st_nxt.irq_msk);
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r       <= '0;
         st_r.ctrl  <= `AMLC_CTRL_RST;
         st_r.cfg   <= `AMLC_CFG_RST;
         st_r.pin_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign event_pin_n_o   = st_r.pin_n;
   assign irq_o           = st_r.irq;
   assign s_axi_awready_o = st_r.awready;
   assign s_axi_wready_o  = st_r.wready;
   assign s_axi_bvalid_o  = st_r.bvalid;
   assign s_axi_bresp_o   = st_r.bresp;
   assign s_axi_arready_o = st_r.arready;
   assign s_axi_rvalid_o  = st_r.rvalid;
   assign s_axi_rdata_o   = st_r.rdata;
   assign s_axi_rresp_o   = st_r.rresp;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   pin_drive_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.cfg[`AMLC_CFG_PIN_EN] && |(st_r.flags & {st_r.ctrl[10:3], 1'b1})
      |=> !event_pin_n_o)
      else $error("unmasked flag did not pull the alarm pin");

   pin_release_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      !st_r.cfg[`AMLC_CFG_PIN_EN] |=> event_pin_n_o)
      else $error("alarm pin driven while disabled");

   masked_quiet_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags == 9'h100 && !st_r.ctrl[10] |=> event_pin_n_o)
      else $error("masked local low flag pulled the pin");

   unmask_high_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags[7] && st_r.ctrl[9] && st_r.cfg[`AMLC_CFG_PIN_EN]
      |=> !event_pin_n_o)
      else $error("unmasked local high flag left the pin high");

   one_low_pin_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags[6] && st_r.ctrl[8] && st_r.cfg[`AMLC_CFG_PIN_EN]
      |=> !event_pin_n_o)
      else $error("unmasked remote one low flag left the pin high");

   one_high_pin_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags[5] && st_r.ctrl[7] && st_r.cfg[`AMLC_CFG_PIN_EN]
      |=> !event_pin_n_o)
      else $error("unmasked remote one high flag left the pin high");

   two_low_pin_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags[4] && st_r.ctrl[6] && st_r.cfg[`AMLC_CFG_PIN_EN]
      |=> !event_pin_n_o)
      else $error("unmasked remote two low flag left the pin high");

   two_high_pin_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags[3] && st_r.ctrl[5] && st_r.cfg[`AMLC_CFG_PIN_EN]
      |=> !event_pin_n_o)
      else $error("unmasked remote two high flag left the pin high");

   one_fail_pin_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags[2] && st_r.ctrl[4] && st_r.cfg[`AMLC_CFG_PIN_EN]
      |=> !event_pin_n_o)
      else $error("unmasked remote one failure left the pin high");

   two_fail_pin_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags[1] && st_r.ctrl[3] && st_r.cfg[`AMLC_CFG_PIN_EN]
      |=> !event_pin_n_o)
      else $error("unmasked remote two failure left the pin high");

   flag_set_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      !st_r.ctrl[`AMLC_LATCH_DIS] && fi.done && fi.qual[0]
      |=> st_r.flags[0])
      else $error("qualified thermal alarm did not set its flag");

   thermal_pin_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.flags[0] && st_r.cfg[`AMLC_CFG_PIN_EN] |=> !event_pin_n_o)
      else $error("thermal flag did not pull the pin");

   latch_hold_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      !st_r.ctrl[`AMLC_LATCH_DIS] && st_r.flags[8] &&
      !(s_axi_arvalid_i && st_r.arready) ##1
      !st_r.ctrl[`AMLC_LATCH_DIS] |-> st_r.flags[8])
      else $error("latched flag dropped without a status read");

   unlatch_follow_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      st_r.ctrl[`AMLC_LATCH_DIS] |=> st_r.flags == $past(fi.qual))
      else $error("unlatched flags did not follow the condition");

   read_clear_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      s_axi_arvalid_i && st_r.arready &&
      s_axi_araddr_i == `AMLC_OFS_STATUS &&
      !st_r.ctrl[`AMLC_LATCH_DIS] && !fi.done |=> st_r.flags == 9'h000)
      else $error("status read did not clear the flags");

   reserved_zero_a: assert property (
      @(posedge mclk_i) disable iff (!reset_n_i)
      (st_r.ctrl & ~`AMLC_CTRL_WMASK) == 16'h0000)
      else $error("reserved control bits are not zero");

   flag_set_c: cover property (
      @(posedge mclk_i) disable iff (!reset_n_i) $rose(st_r.flags[8]));
   pin_low_c: cover property (
      @(posedge mclk_i) disable iff (!reset_n_i) $fell(event_pin_n_o));
   irq_c: cover property (
      @(posedge mclk_i) disable iff (!reset_n_i) $rose(irq_o));
   flag_drop_c: cover property (
      @(posedge mclk_i) disable iff (!reset_n_i) $fell(st_r.flags[8]));
   thermal_clear_c: cover property (
      @(posedge mclk_i) disable iff (!reset_n_i) $fell(st_r.flags[0]));

endmodule : amlc_top

// >>> dv/amlc_host_mdl.sv
`timescale 1ns/1ps
module amlc_host_mdl (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_n_i,
   // Alarm pin as the host sees it
   input  wire logic event_pin_n_i,
   output logic      alarm_seen_o
);
   // The host reads the pin through its own flop, so it lags by one cycle.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) alarm_seen_o <= 1'b0;
      else alarm_seen_o <= !event_pin_n_i;
   end
endmodule : amlc_host_mdl

// >>> dv/testbench.sv
`timescale 1ns/1ps
`include "amlc_cfg.svh"
module testbench;
   logic        mclk_i, reset_n_i;
   logic [8:0]  cond;
   logic        pin_n, irq, seen;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, c0, c;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [33:0] q_rd[$];
   logic [1:0]  q_wr[$];
   logic        lo;
   int          err_count, checks_done, cyc, pos;

   amlc_top i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .alarm_cond_i(cond), .event_pin_n_o(pin_n), .irq_o(irq),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp));
   amlc_host_mdl i_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .event_pin_n_i(pin_n), .alarm_seen_o(seen));

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task give_verdict;
      if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   task cmp_bus(input string what, input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", what, e, g);
      end
   endtask : cmp_bus

   task check_pins(input string what, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %b got %b", what, e, g);
      end
   endtask : check_pins

   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   // A hang is cut short well beyond the longest planned sequence.
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         give_verdict();
      end
   end

   always @(posedge mclk_i) begin
      if (rvalid && rready) cmp_bus("read", q_rd.pop_front(), {rresp, rdata});
      if (bvalid && bready)
         cmp_bus("bresp", {32'h0, q_wr.pop_front()}, {32'h0, bresp});
   end

   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit ad, wd;
      q_wr.push_back(r);
      ad = 0;
      wd = 0;
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      bready  <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge mclk_i);
         if (awvalid && awready) begin ad = 1; awvalid <= 1'b0; end
         if (wvalid && wready) begin wd = 1; wvalid <= 1'b0; end
      end
      do @(posedge mclk_i); while (!bvalid);
      bready <= 1'b0;
      @(posedge mclk_i);
   endtask : axi_wr

   task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      q_rd.push_back({r, e});
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do @(posedge mclk_i); while (!arready);
      arvalid <= 1'b0;
      do @(posedge mclk_i); while (!rvalid);
      rready <= 1'b0;
      @(posedge mclk_i);
   endtask : axi_rd

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(93));
      reset_n_i = 1'b0;
      cond = 9'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      repeat (5) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      axi_rd(`AMLC_OFS_CTRL, 32'h0, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_STATUS, 32'h0, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_CFG, 32'h0, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_IRQ_STS, 32'h0, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_IRQ_MSK, 32'h0, `AMLC_RESP_OKAY);
      check_pins("pin", 1'b1, pin_n);
      axi_wr(`AMLC_OFS_CTRL, 32'hffffffff, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_CTRL, 32'h07fc, `AMLC_RESP_OKAY);
      axi_wr(`AMLC_OFS_STATUS, 32'hffff, `AMLC_RESP_OKAY);
      axi_wr(8'h20, 32'h1, `AMLC_RESP_SLVERR);
      axi_rd(8'h20, 32'h0, `AMLC_RESP_SLVERR);
      axi_wr(`AMLC_OFS_CFG, 32'h4, `AMLC_RESP_OKAY);
      // Each source twice, with a random mask and then its inverse.
      for (int i = 0; i < 9; i++) begin
         c0 = $urandom;
         for (int j = 0; j < 2; j++) begin
            pos = (i == 0) ? 0 : i + 2;
            c = (j == 1 ? ~c0 : c0) & 32'h07f8;
            lo = (i == 0) || c[pos];
            axi_wr(`AMLC_OFS_CTRL, c, `AMLC_RESP_OKAY);
            cond <= 9'h1 << i;
            repeat (900) @(posedge mclk_i);
            cond <= 9'h0;
            repeat (900) @(posedge mclk_i);
            check_pins("pin", !lo, pin_n);
            check_pins("host", lo, seen);
            check_pins("irq", 1'b0, irq);
            axi_rd(`AMLC_OFS_STATUS, 32'h1 << pos, 2'h0);
            axi_rd(`AMLC_OFS_STATUS, 32'h0, 2'h0);
            repeat (3) @(posedge mclk_i);
            check_pins("pin", 1'b1, pin_n);
         end
      end
      axi_rd(`AMLC_OFS_IRQ_STS, 32'h3, `AMLC_RESP_OKAY);
      axi_wr(`AMLC_OFS_IRQ_MSK, 32'h1, `AMLC_RESP_OKAY);
      repeat (2) @(posedge mclk_i);
      check_pins("irq", 1'b1, irq);
      axi_wr(`AMLC_OFS_IRQ_STS, 32'h1, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_IRQ_STS, 32'h2, `AMLC_RESP_OKAY);
      check_pins("irq", 1'b0, irq);
      axi_wr(`AMLC_OFS_IRQ_STS, 32'h2, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_IRQ_STS, 32'h0, `AMLC_RESP_OKAY);
      // Unlatched: a read leaves the flag, the condition ending drops it.
      axi_wr(`AMLC_OFS_CTRL, 32'h404, `AMLC_RESP_OKAY);
      cond <= 9'h100;
      repeat (900) @(posedge mclk_i);
      axi_rd(`AMLC_OFS_STATUS, 32'h400, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_STATUS, 32'h400, `AMLC_RESP_OKAY);
      check_pins("pin", 1'b0, pin_n);
      cond <= 9'h0;
      repeat (900) @(posedge mclk_i);
      axi_rd(`AMLC_OFS_STATUS, 32'h0, `AMLC_RESP_OKAY);
      check_pins("pin", 1'b1, pin_n);
      // Two samples needed: a pulse shorter than one tick is filtered.
      axi_wr(`AMLC_OFS_CTRL, 32'h0, `AMLC_RESP_OKAY);
      axi_wr(`AMLC_OFS_CFG, 32'h5, `AMLC_RESP_OKAY);
      cond <= 9'h1;
      repeat (300) @(posedge mclk_i);
      cond <= 9'h0;
      repeat (900) @(posedge mclk_i);
      axi_rd(`AMLC_OFS_STATUS, 32'h0, `AMLC_RESP_OKAY);
      cond <= 9'h1;
      repeat (1300) @(posedge mclk_i);
      check_pins("pin", 1'b0, pin_n);
      axi_wr(`AMLC_OFS_CFG, 32'h1, `AMLC_RESP_OKAY);
      repeat (3) @(posedge mclk_i);
      check_pins("pin", 1'b1, pin_n);
      axi_rd(`AMLC_OFS_STATUS, 32'h1, `AMLC_RESP_OKAY);
      // A persisting alarm comes back at the next tick; once it ends the
      // latched flag still waits for a read.
      repeat (900) @(posedge mclk_i);
      cond <= 9'h0;
      repeat (900) @(posedge mclk_i);
      axi_rd(`AMLC_OFS_STATUS, 32'h1, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_STATUS, 32'h0, `AMLC_RESP_OKAY);
      // Four samples needed: three ticks of alarm leave the flag clear.
      axi_wr(`AMLC_OFS_CFG, 32'h6, `AMLC_RESP_OKAY);
      cond <= 9'h1;
      repeat (1100) @(posedge mclk_i);
      cond <= 9'h0;
      repeat (900) @(posedge mclk_i);
      axi_rd(`AMLC_OFS_STATUS, 32'h0, `AMLC_RESP_OKAY);
      cond <= 9'h1;
      repeat (2100) @(posedge mclk_i);
      check_pins("pin", 1'b0, pin_n);
      // Reset in mid-run drops every setting and flag.
      axi_wr(`AMLC_OFS_CTRL, 32'h7fc, `AMLC_RESP_OKAY);
      reset_n_i <= 1'b0;
      cond      <= 9'h0;
      repeat (3) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      axi_rd(`AMLC_OFS_CTRL, 32'h0, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_STATUS, 32'h0, `AMLC_RESP_OKAY);
      axi_rd(`AMLC_OFS_CFG, 32'h0, `AMLC_RESP_OKAY);
      check_pins("pin", 1'b1, pin_n);
      give_verdict();
   end
endmodule : testbench
